// ### core/fsf_fifo_flags.sv
// Contract
// - output register word excluded from count
// - shifted word frees its memory location
// - empty flag rises on second read edge
// - late write edge delays first sync cycle
// - full flag low blocks further writes
// - accepted write advances pointer; full synced
// - full machine sees full, -1, -2
// - full flag rises second write edge after read
// - late read edge delays first sync cycle
// - almost-empty sees offset, +1, +2
// - almost-empty low at offset or fewer
// - almost-empty rises second read edge after fill
// - almost-empty sync honours second skew window
// - almost-full sees offset, -1, -2
// - almost-full low at depth minus offset
// - almost-full rises second write edge after read
// - almost-full sync honours second skew window
// - offsets preset on reset, loadable from port
// - flag low: reads ignored, output held (fall-through mode still fetches a stored word into the output while low)
// - fall-through word shows on third edge
// - every flag crosses two flip-flop stages
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps

module fsf_fifo_flags #(
   parameter int DEPTH  = fsf_pkg::DEPTH_DEF,
   parameter int AW     = $clog2(DEPTH),
   parameter int AE_RST = fsf_pkg::AE_OFS_PRESET,
   parameter int AF_RST = fsf_pkg::AF_OFS_PRESET
) (
   // clock and reset
   input  wire logic                         mclk_in,
   input  wire logic                         rst_n_in,
   // mode strap, caught after reset release
   input  wire logic                         first_word_fall_through_mode_in,
   // write port
   input  wire fsf_pkg::fsf_wr_req_t         wr_req_in,
   // offset load through its own strobed offset inputs
   input  wire logic                         offset_load_in,
   input  wire logic [AW:0]                  ae_offset_in,
   input  wire logic [AW:0]                  af_offset_in,
   // read port
   input  wire logic                         rd_en_in,
   output logic [fsf_pkg::DATA_W-1:0]        rd_data_out,
   // flags
   output logic                              empty_or_output_ready_flag_out,
   output logic                              almost_empty_flag_out,
   output logic                              full_or_input_ready_flag_out,
   output logic                              almost_full_flag_out,
   // comparator levels
   output fsf_pkg::fsf_wr_lvl_t              wr_level_out,
   output fsf_pkg::fsf_rd_lvl_t              rd_level_out
);

   // sized copies of the constants, so every compare is AW+1 bits wide
   // pointers carry one extra msb to tell full from empty
   // at equal low bits
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_C   = (AW+1)'(1);
   localparam logic [AW:0] TWO_C   = (AW+1)'(2);
   localparam logic [AW:0] AE_C    = (AW+1)'(AE_RST);
   localparam logic [AW:0] AF_C    = (AW+1)'(AF_RST);

   // storage
   // no reset on the array: only locations between the pointers are read
   logic [fsf_pkg::DATA_W-1:0] mem_q [DEPTH];

   // pointers and their synchronised copies
   // each side compares its own live pointer with a two-stage copy
   // of the other side's pointer, so a flag never sees a half-moved value
   // and the extra latency is what holds a flag low for two edges
   logic [AW:0]          wptr_q;
   logic [AW:0]          rptr_q;
   logic [AW:0]          wptr_s1_q;
   logic [AW:0]          wptr_s2_q;
   logic [AW:0]          rptr_s1_q;
   logic [AW:0]          rptr_s2_q;

   // configuration
   // mode is caught once; offsets follow reset or a parallel load
   logic                 mode_q;
   logic                 mode_done_q;
   logic [AW:0]          ae_ofs_q;
   logic [AW:0]          af_ofs_q;

   // output register state
   fsf_pkg::fsf_out_st_t out_st_q;
   logic [fsf_pkg::DATA_W-1:0] rd_data_q;

   // comparator results
   // counts are modular differences of the wrapped pointers
   logic [AW:0]          count_w;
   logic [AW:0]          count_r;
   logic [AW:0]          af_thr;
   fsf_pkg::fsf_wr_lvl_t wr_lvl;
   fsf_pkg::fsf_rd_lvl_t rd_lvl;
   fsf_pkg::fsf_wr_lvl_t wr_lvl_q;
   fsf_pkg::fsf_rd_lvl_t rd_lvl_q;

   // transfer decisions
   logic                 wr_ok;
   logic                 std_pop;
   logic                 first_word_fall_through_mode_pop;
   logic                 pop;

   // strap capture on the first edge after release
   // mode is frozen afterwards, since switching flag meaning mid-stream
   // would turn an empty flag into an output-ready flag with data in flight
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mode_q      <= 1'b0;
         mode_done_q <= 1'b0;
      end
      else if (!mode_done_q)
      begin
         mode_q      <= first_word_fall_through_mode_in;
         mode_done_q <= 1'b1;
      end
   end

   // offset registers
   // reset loads the presets; a load pulse replaces both at once
   // new thresholds act on the very next comparator evaluation
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ae_ofs_q <= AE_C;
         af_ofs_q <= AF_C;
      end
      else if (offset_load_in)
      begin
         ae_ofs_q <= ae_offset_in;
         af_ofs_q <= af_offset_in;
      end
   end

   // write-side comparator on own pointer and synced read pointer
   // a write shows at once; a read shows only two edges later,
   // so the full and almost-full flags err on the safe side
   // and never report room that has not yet been freed
   always_comb
   begin
      count_w        = wptr_q - rptr_s2_q;
      af_thr         = DEPTH_C - af_ofs_q;
      wr_lvl.full    = (count_w == DEPTH_C);
      wr_lvl.full_m1 = (count_w == DEPTH_C - ONE_C);
      wr_lvl.full_m2 = (count_w == DEPTH_C - TWO_C);
      wr_lvl.af      = (count_w >= af_thr);
      wr_lvl.af_m1   = (count_w == af_thr - ONE_C);
      wr_lvl.af_m2   = (count_w == af_thr - TWO_C);
   end

   // read-side comparator; output register word already left memory
   // a read shows at once; a write shows only two edges later,
   // so the empty and almost-empty flags never promise a word
   // that is still crossing into the read side
   always_comb
   begin
      count_r         = wptr_s2_q - rptr_q;
      rd_lvl.empty    = (count_r == '0);
      rd_lvl.empty_p1 = (count_r == ONE_C);
      rd_lvl.empty_p2 = (count_r == TWO_C);
      rd_lvl.ae       = (count_r <= ae_ofs_q);
      rd_lvl.ae_p1    = (count_r == ae_ofs_q + ONE_C);
      rd_lvl.ae_p2    = (count_r == ae_ofs_q + TWO_C);
   end

   // transfer decisions
   // writes against a full memory and reads against an empty one
   // are dropped here, so pointers can never overtake each other;
   // fall-through mode fetches on its own while the output register is free
   assign wr_ok    = wr_req_in.en && !wr_lvl.full;
   assign std_pop  = !mode_q && rd_en_in && !rd_lvl.empty;
   assign first_word_fall_through_mode_pop = mode_q && !rd_lvl.empty &&
                     ((out_st_q == fsf_pkg::FSF_OUT_EMPTY) || rd_en_in);
   assign pop      = std_pop || first_word_fall_through_mode_pop;

   // memory write, no reset on the array
   // low pointer bits address the array; the msb only marks the lap
   always_ff @(posedge mclk_in)
   begin
      if (wr_ok)
      begin
         mem_q[wptr_q[AW-1:0]] <= wr_req_in.data;
      end
   end

   // write pointer
   // advances only on accepted writes
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wptr_q <= '0;
      end
      else if (wr_ok)
      begin
         wptr_q <= wptr_q + ONE_C;
      end
   end

   // read pointer moves whenever a word enters the output register
   // so the word held there is no longer counted as stored
   // and its old location is offered to the writer again
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rptr_q <= '0;
      end
      else if (pop)
      begin
         rptr_q <= rptr_q + ONE_C;
      end
   end

   // write pointer into the read side, two stages
   // with one clock the skew windows are always met: a write lands
   // a full period before the next edge, so that edge is always
   // the first synchronisation cycle
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wptr_s1_q <= '0;
         wptr_s2_q <= '0;
      end
      else
      begin
         wptr_s1_q <= wptr_q;
         wptr_s2_q <= wptr_s1_q;
      end
   end

   // read pointer into the write side, two stages
   // a read likewise makes its first synchronisation cycle on the
   // next edge, and frees its location on the second
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rptr_s1_q <= '0;
         rptr_s2_q <= '0;
      end
      else
      begin
         rptr_s1_q <= rptr_q;
         rptr_s2_q <= rptr_s1_q;
      end
   end

   // output register: held unless a word is moved in
   // refused reads leave the previous word on the read port
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_q <= '0;
      end
      else if (pop)
      begin
         rd_data_q <= mem_q[rptr_q[AW-1:0]];
      end
   end

   // fall-through occupancy of the output register
   // valid means a fresh word waits for the reader;
   // a read with nothing behind it returns to empty,
   // a read with a word behind it reloads and stays valid
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         out_st_q <= fsf_pkg::FSF_OUT_EMPTY;
      end
      else
      begin
         unique case (out_st_q)
            fsf_pkg::FSF_OUT_EMPTY:
            begin
               if (first_word_fall_through_mode_pop)
               begin
                  out_st_q <= fsf_pkg::FSF_OUT_VALID;
               end
            end
            fsf_pkg::FSF_OUT_VALID:
            begin
               if (rd_en_in && !first_word_fall_through_mode_pop)
               begin
                  out_st_q <= fsf_pkg::FSF_OUT_EMPTY;
               end
            end
         endcase
      end
   end

   // registered comparator levels
   // a one-cycle delayed view of the comparators for monitoring;
   // flags themselves do not wait on this stage
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wr_lvl_q <= '0;
         rd_lvl_q <= '0;
      end
      else
      begin
         wr_lvl_q <= wr_lvl;
         rd_lvl_q <= rd_lvl;
      end
   end

   // flag outputs from the synced comparators
   // all flags are active low in their warning sense:
   // low means empty, almost empty, full or almost full
   // in fall-through mode the ready flag follows the output register
   assign empty_or_output_ready_flag_out = mode_q ? (out_st_q == fsf_pkg::FSF_OUT_VALID)
                                                  : !rd_lvl.empty;
   assign almost_empty_flag_out          = !rd_lvl.ae;
   assign full_or_input_ready_flag_out   = !wr_lvl.full;
   assign almost_full_flag_out           = !wr_lvl.af;

   // data and level outputs, all straight from flip-flops
   assign rd_data_out  = rd_data_q;
   assign wr_level_out = wr_lvl_q;
   assign rd_level_out = rd_lvl_q;

endmodule // fsf_fifo_flags

// ### core/fsf_pkg.sv
package fsf_pkg;

   // data path and memory
   localparam int DATA_W    = 36;
   localparam int DEPTH_DEF = 256;

   // offsets loaded by reset
   localparam int AE_OFS_PRESET = 8;
   localparam int AF_OFS_PRESET = 8;

   // synchroniser flip-flop stages per flag
   localparam int SYNC_STAGES = 2;

   // write port request
   typedef struct packed {
      logic              en;
      logic [DATA_W-1:0] data;
   } fsf_wr_req_t;

   // write-side comparator levels, active high
   typedef struct packed {
      logic full;
      logic full_m1;
      logic full_m2;
      logic af;
      logic af_m1;
      logic af_m2;
   } fsf_wr_lvl_t;

   // read-side comparator levels, active high
   typedef struct packed {
      logic empty;
      logic empty_p1;
      logic empty_p2;
      logic ae;
      logic ae_p1;
      logic ae_p2;
   } fsf_rd_lvl_t;

   // output register occupancy in fall-through mode
   typedef enum logic {
      FSF_OUT_EMPTY,
      FSF_OUT_VALID
   } fsf_out_st_t;

endpackage

// ### verification/fsf_flags_properties.sv
`timescale 1ns/10ps
module fsf_flags_properties #(
   parameter int DEPTH  = 256,
   parameter int AW     = 8,
   parameter int AE_RST = 8,
   parameter int AF_RST = 8
) (
   // clock, reset and mode
   input wire logic                        mclk_in,
   input wire logic                        rst_n_in,
   input wire logic                        first_word_fall_through_mode_in,
   // port requests
   input wire fsf_pkg::fsf_wr_req_t        wr_req_in,
   input wire logic                        offset_load_in,
   input wire logic [AW:0]                 ae_offset_in,
   input wire logic [AW:0]                 af_offset_in,
   input wire logic                        rd_en_in,
   // data and flags
   input wire logic [fsf_pkg::DATA_W-1:0]  rd_data_out,
   input wire logic                        empty_or_output_ready_flag_out,
   input wire logic                        almost_empty_flag_out,
   input wire logic                        full_or_input_ready_flag_out,
   input wire logic                        almost_full_flag_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   logic fw, ef, ff, wa, ra;
   int   wp_q, rp_q, rs1_q, rs2_q, ws1_q, ws2_q, x_q, y_q;
   // accepted transfers; reads counted in standard mode only
   assign fw = first_word_fall_through_mode_in;
   assign ef = empty_or_output_ready_flag_out;
   assign ff = full_or_input_ready_flag_out;
   assign wa = wr_req_in.en && ff;
   assign ra = rd_en_in && ef && !fw;
   // shadow pointers with two-stage crossings, offsets
   always_ff @(posedge mclk_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         {wp_q, rp_q, rs1_q, rs2_q, ws1_q, ws2_q} <= '0;
         x_q <= AE_RST;
         y_q <= AF_RST;
      end
      else
      begin
         wp_q  <= wp_q + int'(wa);
         rp_q  <= rp_q + int'(ra);
         {rs1_q, rs2_q, ws1_q, ws2_q} <= {rp_q, rs1_q, wp_q, ws1_q};
         if (offset_load_in)
         begin
            x_q <= int'(ae_offset_in);
            y_q <= int'(af_offset_in);
         end
      end
   property p_full_lvl; !fw |-> ff == (wp_q - rs2_q < DEPTH); endproperty
   a_full_lvl: assert property (p_full_lvl) else $error("full flag off");
   property p_af_lvl;
      !fw |-> almost_full_flag_out == (wp_q - rs2_q <= DEPTH - y_q - 1);
   endproperty
   a_af_lvl: assert property (p_af_lvl) else $error("almost full off");
   property p_ef_lvl; !fw |-> ef == (ws2_q != rp_q); endproperty
   a_ef_lvl: assert property (p_ef_lvl) else $error("empty flag off");
   property p_ae_lvl; !fw |-> almost_empty_flag_out == (ws2_q - rp_q > x_q); endproperty
   a_ae_lvl: assert property (p_ae_lvl) else $error("almost empty off");
   property p_ef_seq;
      !fw && wa && !ef && !$past(wa) && !$past(wa, 2) |=> !ef [*2] ##1 ef;
   endproperty
   a_ef_seq: assert property (p_ef_seq) else $error("empty rise late");
   property p_ff_seq;
      !fw && ra && !ff && !$past(ra) && !$past(ra, 2) |=> !ff [*2] ##1 ff;
   endproperty
   a_ff_seq: assert property (p_ff_seq) else $error("full rise late");
   property p_hold; !fw && rd_en_in && !ef |=> $stable(rd_data_out); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_fall;
      fw && wa && !ef && !$past(wa) && !$past(wa, 2) && !$past(wa, 3)
      |=> !ef [*3] ##1 (ef && rd_data_out == $past(wr_req_in.data, 4));
   endproperty
   a_fall: assert property (p_fall) else $error("fall-through off");
   // main scenarios reached
   c_full: cover property (!ff);
   c_rise: cover property ($rose(ef));
   c_fall: cover property (fw && ef);
endmodule // fsf_flags_properties

// ### verification/fsf_port_partner.sv
`timescale 1ns/10ps
module fsf_port_partner (
   // clock and reset
   input  wire logic           mclk_in,
   input  wire logic           rst_n_in,
   // pace knobs: 0 off, 1 slow, 2 every cycle
   input  wire logic [1:0]     wr_on_in,
   input  wire logic [1:0]     rd_on_in,
   // port requests
   output fsf_pkg::fsf_wr_req_t wr_req_out,
   output logic                rd_en_out
);
   int seed = 32'h9B40;
   // writer and reader, data changes every cycle
   always @(posedge mclk_in or negedge rst_n_in)
      if (!rst_n_in)
      begin
         wr_req_out <= '0;
         rd_en_out  <= 1'b0;
      end
      else
      begin
         wr_req_out.en   <= wr_on_in[1] || (wr_on_in[0] && $random(seed) % 4 == 0);
         wr_req_out.data <= {4'($random(seed)), $random(seed)};
         rd_en_out       <= rd_on_in[1] || (rd_on_in[0] && $random(seed) % 4 == 0);
      end
endmodule // fsf_port_partner

// ### verification/tb_fsf_fifo_flags.sv
`timescale 1ns/10ps
module tb_fsf_fifo_flags;
   localparam int DEPTH = 256;
   logic                       mclk_in, rst_n_in, first_word_fall_through_mode, ld, rd_en, ef, ae, ff, af, rd_pend;
   logic [1:0]                 wr_on, rd_on;
   logic [8:0]                 aeo, afo;
   logic [fsf_pkg::DATA_W-1:0] rd_data;
   logic [fsf_pkg::DATA_W-1:0] exp_q[$];
   fsf_pkg::fsf_wr_req_t       wr_req;
   fsf_pkg::fsf_wr_lvl_t       wr_lvl;
   fsf_pkg::fsf_rd_lvl_t       rd_lvl;
   int                         err_total = 0;
   int                         n_compared = 0;
   fsf_fifo_flags #(.DEPTH(DEPTH)) dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .first_word_fall_through_mode_in(first_word_fall_through_mode), .wr_req_in(wr_req), .offset_load_in(ld),
      .ae_offset_in(aeo), .af_offset_in(afo), .rd_en_in(rd_en), .rd_data_out(rd_data),
      .empty_or_output_ready_flag_out(ef), .almost_empty_flag_out(ae),
      .full_or_input_ready_flag_out(ff), .almost_full_flag_out(af),
      .wr_level_out(wr_lvl), .rd_level_out(rd_lvl));
   fsf_port_partner partner_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .wr_on_in(wr_on),
      .rd_on_in(rd_on), .wr_req_out(wr_req), .rd_en_out(rd_en));
   task automatic check(string what, logic [63:0] exp, logic [63:0] got);
      n_compared++;
      if (exp !== got)
      begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic go_reset(logic mode);
      rst_n_in <= 1'b0;
      first_word_fall_through_mode     <= mode;
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      exp_q.delete();
      repeat (3) @(posedge mclk_in);
   endtask
   task automatic run(logic [1:0] w, logic [1:0] r, int n);
      wr_on <= w;
      rd_on <= r;
      repeat (n) @(posedge mclk_in);
   endtask
   // clock
   initial
   begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end
   // notes accepted words, compares each read one edge later
   always @(posedge mclk_in)
   begin
      if (rd_pend)
         check("rd_data", exp_q.pop_front(), rd_data);
      rd_pend = rst_n_in && !first_word_fall_through_mode && rd_en && ef;
      if (rst_n_in && wr_req.en && ff)
         exp_q.push_back(wr_req.data);
   end
   // watchdog
   initial
   begin
      #(20 * 20000);
      err_total++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      {rst_n_in, first_word_fall_through_mode, ld, wr_on, rd_on, aeo, afo, rd_pend} = '0;
      go_reset(1'b0);
      check("reset flags", 4'h3, {ef, ae, ff, af});
      check("reset levels", 12'h024, {wr_lvl, rd_lvl});
      run(2'h2, 2'h0, DEPTH + 10);
      check("fill count", DEPTH, exp_q.size());
      check("full flags", 4'hC, {ef, ae, ff, af});
      check("full levels", 12'h900, {wr_lvl, rd_lvl});
      run(2'h0, 2'h2, DEPTH + 10);
      check("drain count", 0, exp_q.size());
      check("empty flags", 4'h3, {ef, ae, ff, af});
      check("empty levels", 12'h024, {wr_lvl, rd_lvl});
      ld  <= 1'b1;
      aeo <= 9'h014;
      afo <= 9'h01E;
      run(2'h0, 2'h0, 1);
      ld <= 1'b0;
      run(2'h2, 2'h1, 1500);
      run(2'h1, 2'h2, 1500);
      run(2'h0, 2'h2, DEPTH + 10);
      check("mixed drain", 0, exp_q.size());
      run(2'h0, 2'h0, 1);
      go_reset(1'b1);
      run(2'h2, 2'h0, 9);
      run(2'h0, 2'h0, 8);
      check("fall ae low", 0, ae);
      check("fall word", exp_q[0], rd_data);
      check("fall ready", 1, ef);
      check("fall levels", 12'h004, {wr_lvl, rd_lvl});
      run(2'h2, 2'h0, 1);
      run(2'h0, 2'h0, 8);
      check("fall ae high", 1, ae);
      check("ae plus one", 12'h002, {wr_lvl, rd_lvl});
      report_and_stop();
   end
endmodule // tb_fsf_fifo_flags
bind fsf_fifo_flags fsf_flags_properties #(.DEPTH(DEPTH), .AW(AW), .AE_RST(AE_RST),
   .AF_RST(AF_RST)) chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .first_word_fall_through_mode_in(first_word_fall_through_mode_in),
   .wr_req_in(wr_req_in), .offset_load_in(offset_load_in), .ae_offset_in(ae_offset_in),
   .af_offset_in(af_offset_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
   .empty_or_output_ready_flag_out(empty_or_output_ready_flag_out),
   .almost_empty_flag_out(almost_empty_flag_out),
   .full_or_input_ready_flag_out(full_or_input_ready_flag_out),
   .almost_full_flag_out(almost_full_flag_out));
